// >>> include/sbf_params.svh
// Constants for the shared byte buffer with fill-level alerts
`ifndef SBF_PARAMS_SVH
`define SBF_PARAMS_SVH

`define SBF_DATA_W 8
`define SBF_DEPTH 512
`define SBF_PTR_W 9
`define SBF_CNT_W 10
`define SBF_THR_W 9
`define SBF_CAP_LARGE 10'h200
`define SBF_CAP_SMALL 10'h0FF
`define SBF_CNT_ZERO 10'h000
`define SBF_CNT_ONE 10'h001
`define SBF_PTR_ZERO 9'h000
`define SBF_PTR_ONE 9'h001
`define SBF_BYTE_ZERO 8'h00
`define SBF_CNT_LO_MSB 7
`define SBF_CNT_HI_LSB 8
`define SBF_CNT_HI_MSB 9

`endif

// >>> include/sbf_pkg.sv
// Types shared by the shared byte buffer files
package sbf_pkg;

	// One byte transfer request into the buffer
	typedef struct packed {
		logic en;
		logic [7:0] data;
	} sbf_wr_t;

	// One registered read answer
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sbf_rd_t;

	// Fill-level flags
	typedef struct packed {
		logic near_full;
		logic near_empty;
	} sbf_flags_t;

endpackage : sbf_pkg

// >>> logic/sbf_mem.sv
// Flip-flop storage array with one write port and one indexed read port
`timescale 1ns/10ps

module sbf_mem #(
	parameter int DATA_W = 8,
	parameter int DEPTH = 512,
	parameter int ADDR_W = 9
) (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	// Read port
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);

	logic [DATA_W-1:0] mem_reg [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_reg[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem_reg[rd_addr];

endmodule : sbf_mem

// >>> logic/sbf_rise.sv
// Sticky rising-edge event on a flag, gated onto an interrupt term
`timescale 1ns/10ps

module sbf_rise (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Flag and control
	input wire logic level,
	input wire logic enable,
	input wire logic clear,
	// Results
	output logic event_out,
	output logic irq_out
);

	logic last_reg;
	logic last_next;
	logic event_reg;
	logic event_next;

	always_comb begin
		last_next = level;
		// Set wins over clear
		event_next = (level & ~last_reg) | (event_reg & ~clear);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			last_reg <= 1'b0;
			event_reg <= 1'b0;
		end else begin
			last_reg <= last_next;
			event_reg <= event_next;
		end
	end

	assign event_out = event_reg;
	assign irq_out = event_reg & enable;

endmodule : sbf_rise

// >>> logic/sbf_top.sv
// Shared byte buffer between host and command engine, with fill count and alerts
//
// What this block does
// R1: One storage array serves host and engine writes and reads alike.
// R2: Host must not disturb buffer traffic while the engine runs a command; the block has no command state, engine requests only win each cycle.
// R3: A flush pulse clears both pointers and the fill count to zero.
// R4: Capacity is 512 bytes, or 255 bytes when small capacity is selected.
// R5: Every stored byte adds one to the count, every read byte subtracts one.
// R6: Count low byte and its upper bits are presented as separate outputs.
// R7: Threshold is one high bit plus a low byte, spanning the large range.
// R8: One threshold value drives both the near-full and near-empty flags.
// R9: Near-full is set while free space is at or below the threshold.
// R10: Near-empty is set while the fill count is at or below the threshold.
// R11: Host write into a full buffer sets the sticky overflow error bit.
// R12: Near-empty rising edge raises the interrupt when its enable is set.
// R13: Near-full rising edge raises the interrupt when its enable is set.
// R14: In small mode writes stop at a count of 255, so the count fits in one byte unless it was larger when selected; the threshold still uses its high bit.
// R15: A write into a full buffer stores nothing and leaves pointers and count unchanged.
// R16: A read from an empty buffer changes nothing; count never wraps.
`timescale 1ns/10ps
`include "sbf_params.svh"

module sbf_top #(
	parameter int DATA_W = `SBF_DATA_W,
	parameter int DEPTH = `SBF_DEPTH,
	parameter int PTR_W = `SBF_PTR_W
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Host write and read
	input wire logic HOST_WR_EN,
	input wire logic [DATA_W-1:0] HOST_WR_DATA,
	input wire logic HOST_RD_EN,
	output logic [DATA_W-1:0] HOST_RD_DATA,
	output logic HOST_RD_VALID,
	// Engine write and read
	input wire logic ENG_WR_EN,
	input wire logic [DATA_W-1:0] ENG_WR_DATA,
	input wire logic ENG_RD_EN,
	output logic [DATA_W-1:0] ENG_RD_DATA,
	output logic ENG_RD_VALID,
	// Configuration
	input wire logic BUFFER_POINTER_CLEAR,
	input wire logic SMALL_CAPACITY_SELECT,
	input wire logic ALERT_THRESHOLD_HI,
	input wire logic [7:0] ALERT_THRESHOLD_LO,
	input wire logic NEAR_EMPTY_INT_ENABLE,
	input wire logic NEAR_FULL_INT_ENABLE,
	// Event clears
	input wire logic ERROR_EVENT_CLEAR,
	input wire logic NEAR_EMPTY_EVENT_CLEAR,
	input wire logic NEAR_FULL_EVENT_CLEAR,
	// Status
	output logic [7:0] FILL_COUNT_LO,
	output logic [1:0] FILL_COUNT_HI,
	output logic NEAR_FULL_FLAG,
	output logic NEAR_EMPTY_FLAG,
	output logic ERROR_EVENT_BIT,
	output logic NEAR_EMPTY_EVENT,
	output logic NEAR_FULL_EVENT,
	output logic BUFFER_FULL,
	output logic BUFFER_EMPTY,
	// Interrupt request
	output logic IRQ
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	sbf_pkg::sbf_wr_t host_wr;
	sbf_pkg::sbf_wr_t eng_wr;
	sbf_pkg::sbf_wr_t wr_sel;
	sbf_pkg::sbf_rd_t host_rd_reg;
	sbf_pkg::sbf_rd_t host_rd_next;
	sbf_pkg::sbf_rd_t eng_rd_reg;
	sbf_pkg::sbf_rd_t eng_rd_next;
	sbf_pkg::sbf_flags_t flags_reg;
	sbf_pkg::sbf_flags_t flags_next;

	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] wr_ptr_next;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_next;
	logic [`SBF_CNT_W-1:0] count_reg;
	logic [`SBF_CNT_W-1:0] count_next;
	logic overflow_reg;
	logic overflow_next;

	logic [`SBF_CNT_W-1:0] capacity;
	logic [PTR_W-1:0] last_index;
	logic [`SBF_CNT_W-1:0] threshold;
	logic [`SBF_CNT_W-1:0] free_next;
	logic [DATA_W-1:0] mem_rd_data;
	logic full;
	logic empty;
	logic wr_req;
	logic wr_ok;
	logic rd_req;
	logic rd_ok;
	logic rd_to_host;
	logic ovf_set;
	logic ne_irq;
	logic nf_irq;

	////////////////////////////////////////////////////////////////////////////
	// Request carriers

	assign host_wr.en = HOST_WR_EN;
	assign host_wr.data = HOST_WR_DATA;
	assign eng_wr.en = ENG_WR_EN;
	assign eng_wr.data = ENG_WR_DATA;

	////////////////////////////////////////////////////////////////////////////
	// Capacity and threshold

	always_comb begin
		// R4 capacity select
		capacity = SMALL_CAPACITY_SELECT ? `SBF_CAP_SMALL : `SBF_CAP_LARGE;
		last_index = PTR_W'(capacity - `SBF_CNT_ONE);
		// R7 threshold assembly
		threshold = {1'b0, ALERT_THRESHOLD_HI, ALERT_THRESHOLD_LO};
		full = (count_reg >= capacity);
		empty = (count_reg == `SBF_CNT_ZERO);
	end

	////////////////////////////////////////////////////////////////////////////
	// Shared storage

	// R1 single shared array
	sbf_mem #(
		.DATA_W(DATA_W),
		.DEPTH(DEPTH),
		.ADDR_W(PTR_W)
	) u_mem (
		.clk(CLK),
		.wr_en(wr_ok),
		.wr_addr(wr_ptr_reg),
		.wr_data(wr_sel.data),
		.rd_addr(rd_ptr_reg),
		.rd_data(mem_rd_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Access arbitration and pointers

	always_comb begin
		// R1 engine takes the port first
		wr_sel = eng_wr.en ? eng_wr : host_wr;
		wr_req = eng_wr.en | host_wr.en;
		// R15 refuse write when full
		wr_ok = wr_req & ~full & ~BUFFER_POINTER_CLEAR;
		rd_req = ENG_RD_EN | HOST_RD_EN;
		rd_to_host = ~ENG_RD_EN;
		// R16 refuse read when empty
		rd_ok = rd_req & ~empty & ~BUFFER_POINTER_CLEAR;
		// R11 host overflow detect
		ovf_set = host_wr.en & full & ~BUFFER_POINTER_CLEAR;

		wr_ptr_next = wr_ptr_reg;
		rd_ptr_next = rd_ptr_reg;
		count_next = count_reg;
		if (BUFFER_POINTER_CLEAR) begin
			// R3 flush pointers and count
			wr_ptr_next = `SBF_PTR_ZERO;
			rd_ptr_next = `SBF_PTR_ZERO;
			count_next = `SBF_CNT_ZERO;
		end else begin
			if (wr_ok) begin
				wr_ptr_next = (wr_ptr_reg >= last_index) ? `SBF_PTR_ZERO :
					wr_ptr_reg + `SBF_PTR_ONE;
			end
			if (rd_ok) begin
				rd_ptr_next = (rd_ptr_reg >= last_index) ? `SBF_PTR_ZERO :
					rd_ptr_reg + `SBF_PTR_ONE;
			end
			// R5 count tracks writes and reads
			case ({wr_ok, rd_ok})
				2'b10: begin
					count_next = count_reg + `SBF_CNT_ONE;
				end
				2'b01: begin
					count_next = count_reg - `SBF_CNT_ONE;
				end
				default: begin
					count_next = count_reg;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			wr_ptr_reg <= `SBF_PTR_ZERO;
			rd_ptr_reg <= `SBF_PTR_ZERO;
			count_reg <= `SBF_CNT_ZERO;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg <= count_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read answers

	always_comb begin
		host_rd_next.valid = rd_ok & rd_to_host;
		host_rd_next.data = host_rd_reg.data;
		eng_rd_next.valid = rd_ok & ~rd_to_host;
		eng_rd_next.data = eng_rd_reg.data;
		if (rd_ok & rd_to_host) begin
			host_rd_next.data = mem_rd_data;
		end
		if (rd_ok & ~rd_to_host) begin
			eng_rd_next.data = mem_rd_data;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			host_rd_reg <= {1'b0, `SBF_BYTE_ZERO};
			eng_rd_reg <= {1'b0, `SBF_BYTE_ZERO};
		end else begin
			host_rd_reg <= host_rd_next;
			eng_rd_reg <= eng_rd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fill-level flags and overflow

	always_comb begin
		free_next = (count_next >= capacity) ? `SBF_CNT_ZERO : capacity - count_next;
		// R8 one threshold for both flags
		// R9 near-full compare
		flags_next.near_full = (free_next <= threshold);
		// R10 near-empty compare
		flags_next.near_empty = (count_next <= threshold);
		// R11 sticky overflow, set wins
		overflow_next = ovf_set | (overflow_reg & ~ERROR_EVENT_CLEAR);
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			flags_reg <= 2'b00;
			overflow_reg <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			overflow_reg <= overflow_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alert events

	// R12 near-empty edge event
	sbf_rise u_ne_rise (
		.clk(CLK),
		.rst_b(RST_B),
		.level(flags_reg.near_empty),
		.enable(NEAR_EMPTY_INT_ENABLE),
		.clear(NEAR_EMPTY_EVENT_CLEAR),
		.event_out(NEAR_EMPTY_EVENT),
		.irq_out(ne_irq)
	);

	// R13 near-full edge event
	sbf_rise u_nf_rise (
		.clk(CLK),
		.rst_b(RST_B),
		.level(flags_reg.near_full),
		.enable(NEAR_FULL_INT_ENABLE),
		.clear(NEAR_FULL_EVENT_CLEAR),
		.event_out(NEAR_FULL_EVENT),
		.irq_out(nf_irq)
	);

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// R6 count split across outputs
	// R14 small mode stops writes at 255; a larger count left from large mode stays in the upper bits
	assign FILL_COUNT_LO = count_reg[`SBF_CNT_LO_MSB:0];
	assign FILL_COUNT_HI = count_reg[`SBF_CNT_HI_MSB:`SBF_CNT_HI_LSB];
	assign NEAR_FULL_FLAG = flags_reg.near_full;
	assign NEAR_EMPTY_FLAG = flags_reg.near_empty;
	assign ERROR_EVENT_BIT = overflow_reg;
	assign BUFFER_FULL = full;
	assign BUFFER_EMPTY = empty;
	assign HOST_RD_DATA = host_rd_reg.data;
	assign HOST_RD_VALID = host_rd_reg.valid;
	assign ENG_RD_DATA = eng_rd_reg.data;
	assign ENG_RD_VALID = eng_rd_reg.valid;
	assign IRQ = ne_irq | nf_irq;

endmodule : sbf_top

// >>> bench/sbf_eng_model.sv
// Command engine stand-in on the engine side of the buffer
`timescale 1ns/10ps

module sbf_eng_model (
	// Clock
	input wire logic clk,
	// Engine side
	output logic eng_wr_en,
	output logic [7:0] eng_wr_data,
	output logic eng_rd_en,
	input wire logic eng_rd_valid,
	input wire logic [7:0] eng_rd_data
);
	initial begin
		eng_wr_en = 1'b0;
		eng_wr_data = 8'h00;
		eng_rd_en = 1'b0;
	end
	task automatic put(input logic [7:0] d);
		eng_wr_en = 1'b1;
		eng_wr_data = d;
		@(posedge clk);
		#1;
		eng_wr_en = 1'b0;
		eng_wr_data = ~d;
		// Idle edge so back-to-back calls never retoggle the strobe in one step
		@(posedge clk);
		#1;
	endtask : put
	task automatic get(output logic [7:0] d, output logic v);
		eng_rd_en = 1'b1;
		@(posedge clk);
		#1;
		eng_rd_en = 1'b0;
		v = eng_rd_valid;
		d = eng_rd_data;
		// Idle edge so back-to-back calls never retoggle the strobe in one step
		@(posedge clk);
		#1;
	endtask : get
endmodule : sbf_eng_model

// >>> bench/sbf_chk.sv
// Port checks for the shared byte buffer
`timescale 1ns/10ps

module sbf_chk (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Requests and configuration
	input wire logic HOST_WR_EN,
	input wire logic HOST_RD_EN,
	input wire logic ENG_WR_EN,
	input wire logic ENG_RD_EN,
	input wire logic BUFFER_POINTER_CLEAR,
	input wire logic SMALL_CAPACITY_SELECT,
	input wire logic ALERT_THRESHOLD_HI,
	input wire logic [7:0] ALERT_THRESHOLD_LO,
	input wire logic NEAR_FULL_INT_ENABLE,
	// Status
	input wire logic [7:0] FILL_COUNT_LO,
	input wire logic [1:0] FILL_COUNT_HI,
	input wire logic NEAR_FULL_FLAG,
	input wire logic NEAR_EMPTY_FLAG,
	input wire logic ERROR_EVENT_BIT,
	input wire logic NEAR_EMPTY_EVENT,
	input wire logic HOST_RD_VALID,
	input wire logic BUFFER_FULL,
	input wire logic BUFFER_EMPTY,
	input wire logic IRQ
);
	logic [9:0] cnt;
	logic [9:0] cap;
	logic [9:0] thr;
	logic [9:0] free;
	logic rd_any;
	logic up_reg;
	logic up_next;
	assign cnt = {FILL_COUNT_HI, FILL_COUNT_LO};
	assign cap = SMALL_CAPACITY_SELECT ? 10'h0FF : 10'h200;
	assign thr = {1'b0, ALERT_THRESHOLD_HI, ALERT_THRESHOLD_LO};
	assign free = (cnt > cap) ? 10'h000 : cap - cnt;
	assign rd_any = HOST_RD_EN | ENG_RD_EN;
	always_comb begin
		up_next = RST_B;
	end
	always_ff @(posedge CLK) begin
		up_reg <= up_next;
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////
	a_flag_empty: assert property (up_reg && $stable(thr) |-> NEAR_EMPTY_FLAG == (cnt <= thr))
		else $error("near-empty flag wrong");
	a_flag_full: assert property (up_reg && $stable(thr) && $stable(cap)
		|-> NEAR_FULL_FLAG == (free <= thr))
		else $error("near-full flag wrong");
	a_cap_full: assert property (up_reg && $stable(cap) |-> BUFFER_FULL == (cnt >= cap))
		else $error("full flag disagrees with capacity");
	a_flush_clear: assert property (BUFFER_POINTER_CLEAR |=> cnt == 10'h000 && BUFFER_EMPTY)
		else $error("flush left bytes");
	a_wr_count: assert property (HOST_WR_EN && !BUFFER_FULL && !rd_any && !BUFFER_POINTER_CLEAR
		|=> cnt == $past(cnt) + 10'h001)
		else $error("write did not add one");
	a_rd_count: assert property (rd_any && !BUFFER_EMPTY && !HOST_WR_EN && !ENG_WR_EN
		&& !BUFFER_POINTER_CLEAR |=> cnt == $past(cnt) - 10'h001)
		else $error("read did not take one");
	a_ovf_set: assert property (HOST_WR_EN && BUFFER_FULL && !BUFFER_POINTER_CLEAR
		|=> ERROR_EVENT_BIT)
		else $error("overflow not flagged");
	a_full_hold: assert property (HOST_WR_EN && BUFFER_FULL && !rd_any && !BUFFER_POINTER_CLEAR
		|=> $stable(cnt))
		else $error("write into full buffer changed count");
	a_empty_read: assert property (HOST_RD_EN && BUFFER_EMPTY && !HOST_WR_EN && !ENG_WR_EN
		|=> !HOST_RD_VALID && cnt == 10'h000)
		else $error("read from empty buffer answered");
	a_event_rise: assert property ($rose(NEAR_EMPTY_FLAG) |=> NEAR_EMPTY_EVENT)
		else $error("near-empty event missed");
	a_irq_full: assert property ($rose(NEAR_FULL_FLAG) && NEAR_FULL_INT_ENABLE |=> IRQ)
		else $error("near-full interrupt missed");
endmodule : sbf_chk

bind sbf_top sbf_chk sbf_chk_i (.*);

// >>> bench/sbf_top_tb_top.sv
// Self-checking bench for the shared byte buffer
`timescale 1ns/10ps

module sbf_top_tb_top;
	logic CLK = 1'b0;
	logic RST_B = 1'b0;
	logic HOST_WR_EN = 1'b0;
	logic [7:0] HOST_WR_DATA = 8'h00;
	logic HOST_RD_EN = 1'b0;
	logic BUFFER_POINTER_CLEAR = 1'b0;
	logic SMALL_CAPACITY_SELECT = 1'b0;
	logic ALERT_THRESHOLD_HI = 1'b0;
	logic [7:0] ALERT_THRESHOLD_LO = 8'h04;
	logic NEAR_EMPTY_INT_ENABLE = 1'b1;
	logic NEAR_FULL_INT_ENABLE = 1'b1;
	logic ERROR_EVENT_CLEAR = 1'b0;
	logic NEAR_EMPTY_EVENT_CLEAR = 1'b0;
	logic NEAR_FULL_EVENT_CLEAR = 1'b0;
	logic ENG_WR_EN, ENG_RD_EN, HOST_RD_VALID, ENG_RD_VALID, NEAR_FULL_FLAG, NEAR_EMPTY_FLAG;
	logic ERROR_EVENT_BIT, NEAR_EMPTY_EVENT, NEAR_FULL_EVENT, BUFFER_FULL, BUFFER_EMPTY, IRQ;
	logic [7:0] ENG_WR_DATA, HOST_RD_DATA, ENG_RD_DATA, FILL_COUNT_LO, d;
	logic [1:0] FILL_COUNT_HI;
	logic [9:0] cnt;
	logic v;
	int err_count = 0;
	int compares = 0;
	assign cnt = {FILL_COUNT_HI, FILL_COUNT_LO};
	always #4 CLK = ~CLK;
	sbf_top sbf_top_i (.*);
	sbf_eng_model sbf_eng_model_i (.clk(CLK), .eng_wr_en(ENG_WR_EN), .eng_wr_data(ENG_WR_DATA),
		.eng_rd_en(ENG_RD_EN), .eng_rd_valid(ENG_RD_VALID), .eng_rd_data(ENG_RD_DATA));
	////////////////////////////////////////
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick;
		@(posedge CLK);
		#1;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick;
		s = 1'b0;
	endtask : pulse
	task automatic wr(input int n, input logic [7:0] b);
		for (int i = 0; i < n; i++) begin
			HOST_WR_EN = 1'b1;
			HOST_WR_DATA = b + i[7:0];
			tick;
		end
		HOST_WR_EN = 1'b0;
		HOST_WR_DATA = ~HOST_WR_DATA;
		tick;
	endtask : wr
	task automatic rd(input logic ev, input logic [7:0] ed);
		HOST_RD_EN = 1'b1;
		tick;
		HOST_RD_EN = 1'b0;
		chk(HOST_RD_VALID, ev);
		if (ev) chk(HOST_RD_DATA, ed);
		tick;
	endtask : rd
	task automatic end_of_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge CLK);
		err_count++;
		end_of_test;
	end
	initial begin
		repeat (10) @(posedge CLK);
		#1;
		RST_B = 1'b1;
		tick;
		tick;
		chk(NEAR_EMPTY_EVENT, 1'b1);
		chk(IRQ, 1'b1);
		NEAR_EMPTY_INT_ENABLE = 1'b0;
		pulse(NEAR_EMPTY_EVENT_CLEAR);
		chk(IRQ, 1'b0);
		wr(6, 8'hA0);
		chk(cnt, 10'h006);
		chk(NEAR_EMPTY_FLAG, 1'b0);
		sbf_eng_model_i.get(d, v);
		chk(d, 8'hA0);
		chk(v, 1'b1);
		sbf_eng_model_i.get(d, v);
		chk(d, 8'hA1);
		chk(v, 1'b1);
		chk(NEAR_EMPTY_FLAG, 1'b1);
		tick;
		chk(NEAR_EMPTY_EVENT, 1'b1);
		chk(IRQ, 1'b0);
		sbf_eng_model_i.put(8'h5A);
		for (int i = 2; i < 6; i++) rd(1'b1, 8'hA0 + i[7:0]);
		rd(1'b1, 8'h5A);
		rd(1'b0, 8'h00);
		chk(cnt, 10'h000);
		SMALL_CAPACITY_SELECT = 1'b1;
		tick;
		wr(250, 8'h00);
		chk(NEAR_FULL_FLAG, 1'b0);
		wr(1, 8'h00);
		chk(NEAR_FULL_FLAG, 1'b1);
		tick;
		chk(NEAR_FULL_EVENT, 1'b1);
		chk(IRQ, 1'b1);
		wr(4, 8'h00);
		chk(BUFFER_FULL, 1'b1);
		chk(FILL_COUNT_HI, 2'h0);
		wr(1, 8'h00);
		tick;
		chk(ERROR_EVENT_BIT, 1'b1);
		chk(cnt, 10'h0FF);
		pulse(ERROR_EVENT_CLEAR);
		chk(ERROR_EVENT_BIT, 1'b0);
		pulse(BUFFER_POINTER_CLEAR);
		chk(cnt, 10'h000);
		rd(1'b0, 8'h00);
		SMALL_CAPACITY_SELECT = 1'b0;
		ALERT_THRESHOLD_HI = 1'b1;
		pulse(NEAR_FULL_EVENT_CLEAR);
		wr(251, 8'h40);
		chk(NEAR_FULL_FLAG, 1'b0);
		chk(NEAR_EMPTY_FLAG, 1'b1);
		wr(261, 8'h40);
		chk(FILL_COUNT_HI, 2'h2);
		chk(FILL_COUNT_LO, 8'h00);
		chk(BUFFER_FULL, 1'b1);
		sbf_eng_model_i.get(d, v);
		chk(d, 8'h40);
		chk(v, 1'b1);
		end_of_test;
	end
endmodule : sbf_top_tb_top
